// *** rtl/cfg_header.v ***
// Configuration header register bank with access types and command-bit transaction gating.
`default_nettype none
`include "cfg_header_map.vh"
// Behaviour
// R1: A write-one-to-clear bit is cleared where a write carries 1 and kept where it carries 0.
// R2: Mixed-port bits ignore primary-side writes and accept secondary-side writes, readable from both.
// R3: Sticky read-only, read/write and write-one-to-clear bits keep their value across ordinary resets.
// R4: Bits 15:0 of word 00h return a fixed vendor code and ignore writes.
// R5: Bits 31:16 of word 00h return a fixed device code and ignore writes.
// R6: Command bit 0 gates response to primary I/O transactions and resets to 0.
// R7: Command bit 1 gates acceptance of primary memory reads and resets to 0.
// R8: With command bit 2 clear the bridge neither masters on primary nor answers memory or I/O on secondary.
// R9: With command bit 2 set the bridge masters on primary for traffic forwarded from secondary.
// R10: In reverse mode with a PCI-X primary, split completions may be initiated regardless of bit 2.
// R11: Writes to read-only fields complete normally and change nothing.
module cfg_header (
    // Clock, enable and resets
    input wire clk_in,
    input wire ce_in,
    input wire arst_n_in,
    input wire sticky_arst_n_in,
    // Configuration access port
    input wire cfg_req_in,
    input wire cfg_wr_in,
    input wire cfg_from_secondary_in,
    input wire [5:0] cfg_index_in,
    input wire [3:0] cfg_be_in,
    input wire [31:0] cfg_wdata_in,
    output wire cfg_ack_out,
    output reg [31:0] cfg_rdata_out,
    // Hardware status inputs
    input wire [15:0] w1c_set_in,
    input wire [15:0] sticky_ro_in,
    // Transaction gating
    input wire pri_io_req_in,
    input wire pri_mem_rd_req_in,
    input wire sec_memio_req_in,
    input wire fwd_master_req_in,
    input wire split_cpl_req_in,
    input wire reverse_pcix_in,
    output wire pri_io_accept_out,
    output wire pri_mem_rd_accept_out,
    output wire sec_memio_accept_out,
    output wire pri_master_go_out,
    output wire split_cpl_go_out,
    // Mixed-port control bits
    output wire [15:0] mixed_bits_out
);
    reg rst_meta_reg;
    reg rst_sync_reg;
    reg srst_meta_reg;
    reg srst_sync_reg;
    wire rst_n = rst_sync_reg;
    wire srst_n = srst_sync_reg;

    reg [2:0] cmd_reg;
    reg [2:0] cmd_next;
    reg [15:0] mixed_reg;
    reg [15:0] mixed_next;
    reg [15:0] sticky_rw_reg;
    reg [15:0] sticky_rw_next;
    reg [15:0] sticky_w1c_reg;
    reg [15:0] sticky_w1c_next;
    reg [15:0] w1c_reg;
    reg [15:0] w1c_next;
    reg [15:0] sticky_ro_reg;
    reg [15:0] sticky_ro_next;
    reg [31:0] rdata_next;

    wire access_taken = ce_in & cfg_req_in;
    wire wr_en = access_taken & cfg_wr_in;
    wire rd_en = access_taken & ~cfg_wr_in;

    function [15:0] lane_mask;
        input [1:0] be;
        begin
            lane_mask = {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function index_hit;
        input [5:0] index;
        input [5:0] target;
        begin
            index_hit = (index == target);
        end
    endfunction

    function [15:0] lane_merge;
        input [15:0] old_value;
        input [15:0] new_value;
        input [15:0] mask;
        begin
            lane_merge = (old_value & ~mask) | (new_value & mask);
        end
    endfunction

    // A hardware set in the same cycle as a clear wins, so no event is lost in a cycle with ce_in high.
    function [15:0] w1c_merge;
        input [15:0] old_value;
        input [15:0] clear_bits;
        input [15:0] mask;
        input [15:0] set_bits;
        begin
            w1c_merge = (old_value & ~(clear_bits & mask)) | set_bits;
        end
    endfunction

    wire [15:0] lo_mask = lane_mask(cfg_be_in[1:0]);
    wire [15:0] hi_mask = lane_mask(cfg_be_in[3:2]);

    wire hit_id = index_hit(cfg_index_in, `CFG_OFF_ID);
    wire hit_cmd = index_hit(cfg_index_in, `CFG_OFF_CMD);
    wire hit_sticky = index_hit(cfg_index_in, `CFG_OFF_STICKY);
    wire hit_w1c = index_hit(cfg_index_in, `CFG_OFF_W1C);
    wire hit_mixed = index_hit(cfg_index_in, `CFG_OFF_MIXED);

    wire io_enable = cmd_reg[`CMD_IO_BIT];
    wire mem_enable = cmd_reg[`CMD_MEM_BIT];
    wire master_enable = cmd_reg[`CMD_MASTER_BIT];

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Sticky bits sit on their own power-on reset so ordinary resets leave them alone.
    always @(posedge clk_in or negedge sticky_arst_n_in) begin
        if (!sticky_arst_n_in) begin
            srst_meta_reg <= 1'b0;
            srst_sync_reg <= 1'b0;
        end else begin
            srst_meta_reg <= 1'b1;
            srst_sync_reg <= srst_meta_reg;
        end
    end

    // Command bits take a write only when the low byte lane is enabled.
    always @* begin
        cmd_next = cmd_reg;
        if (wr_en && hit_cmd && cfg_be_in[0]) begin
            cmd_next = cfg_wdata_in[2:0]; // R6 R7 R8
        end
    end

    // A primary-side write to the mixed-port word is acknowledged but dropped.
    always @* begin
        mixed_next = mixed_reg;
        if (wr_en && hit_mixed && cfg_from_secondary_in) begin
            mixed_next = lane_merge(mixed_reg, cfg_wdata_in[15:0], lo_mask); // R2
        end
    end

    always @* begin
        w1c_next = w1c_reg | w1c_set_in;
        if (wr_en && hit_w1c) begin
            w1c_next = w1c_merge(w1c_reg, cfg_wdata_in[15:0], lo_mask, w1c_set_in); // R1
        end
    end

    always @* begin
        sticky_rw_next = sticky_rw_reg;
        if (wr_en && hit_sticky) begin
            sticky_rw_next = lane_merge(sticky_rw_reg, cfg_wdata_in[15:0], lo_mask); // R3
        end
    end

    always @* begin
        sticky_w1c_next = sticky_w1c_reg | w1c_set_in;
        if (wr_en && hit_sticky) begin
            sticky_w1c_next = w1c_merge(sticky_w1c_reg, cfg_wdata_in[31:16], hi_mask, w1c_set_in); // R1 R3
        end
    end

    always @* begin
        sticky_ro_next = sticky_ro_in; // R3
    end

    // The identifier word has no storage at all, so writes there fall through untouched.
    always @* begin
        case (cfg_index_in)
            `CFG_OFF_ID: rdata_next = {`DEVICE_CODE, `VENDOR_CODE}; // R4 R5
            `CFG_OFF_CMD: rdata_next = {29'h00000000, cmd_reg};
            `CFG_OFF_STICKY: rdata_next = {sticky_w1c_reg, sticky_rw_reg};
            `CFG_OFF_W1C: rdata_next = {sticky_ro_reg, w1c_reg};
            `CFG_OFF_MIXED: rdata_next = {16'h0000, mixed_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= `CMD_RESET; // R6 R7 R8
        end else if (ce_in) begin
            cmd_reg <= cmd_next;
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mixed_reg <= `MIXED_RESET;
        end else if (ce_in) begin
            mixed_reg <= mixed_next;
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            w1c_reg <= 16'h0000;
        end else if (ce_in) begin
            w1c_reg <= w1c_next;
        end
    end

    // The sticky words hang on the power-on reset only.
    always @(posedge clk_in or negedge srst_n) begin
        if (!srst_n) begin
            sticky_rw_reg <= 16'h0000; // R3
        end else if (ce_in) begin
            sticky_rw_reg <= sticky_rw_next;
        end
    end

    always @(posedge clk_in or negedge srst_n) begin
        if (!srst_n) begin
            sticky_w1c_reg <= 16'h0000; // R3
        end else if (ce_in) begin
            sticky_w1c_reg <= sticky_w1c_next;
        end
    end

    always @(posedge clk_in or negedge srst_n) begin
        if (!srst_n) begin
            sticky_ro_reg <= 16'h0000; // R3
        end else if (ce_in) begin
            sticky_ro_reg <= sticky_ro_next;
        end
    end

    // Read data holds between reads so a slow host can pick it up late.
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata_out <= 32'h00000000;
        end else if (rd_en) begin
            cfg_rdata_out <= rdata_next;
        end
    end

    // Every access, read-only targets included, is answered in the same cycle.
    assign cfg_ack_out = access_taken; // R11

    assign pri_io_accept_out = pri_io_req_in & io_enable; // R6
    assign pri_mem_rd_accept_out = pri_mem_rd_req_in & mem_enable; // R7
    assign sec_memio_accept_out = sec_memio_req_in & master_enable; // R8
    assign pri_master_go_out = fwd_master_req_in & master_enable; // R8 R9

    // Split completions bypass the master gate only when reverse mode has a PCI-X primary.
    assign split_cpl_go_out = split_cpl_req_in & (reverse_pcix_in | master_enable); // R10

    assign mixed_bits_out = mixed_reg;
endmodule
`default_nettype wire

// *** rtl/cfg_header_map.vh ***
// Offsets, field positions, reset values and identity codes for the bridge configuration header.
`ifndef CFG_HEADER_MAP_VH
`define CFG_HEADER_MAP_VH
`define CFG_OFF_ID 6'h00
`define CFG_OFF_CMD 6'h01
`define CFG_OFF_STICKY 6'h02
`define CFG_OFF_W1C 6'h03
`define CFG_OFF_MIXED 6'h04
`define VENDOR_CODE 16'h1a2b
`define DEVICE_CODE 16'h3c4d
`define CMD_IO_BIT 0
`define CMD_MEM_BIT 1
`define CMD_MASTER_BIT 2
`define CMD_RESET 3'h0
`define MIXED_RESET 16'h0000
`endif

// *** tb/cfg_header_monitor.sv ***
// Port-level assertions for the configuration header bank.
`default_nettype none
`include "cfg_header_map.vh"
module cfg_header_monitor (
    input wire clk_in, ce_in, arst_n_in, cfg_req_in, cfg_wr_in, cfg_from_secondary_in, cfg_ack_out,
    input wire [5:0] cfg_index_in,
    input wire [3:0] cfg_be_in,
    input wire [31:0] cfg_wdata_in, cfg_rdata_out,
    input wire pri_io_accept_out, pri_mem_rd_req_in, pri_mem_rd_accept_out, sec_memio_req_in,
    input wire sec_memio_accept_out, fwd_master_req_in, pri_master_go_out,
    input wire split_cpl_req_in, reverse_pcix_in, split_cpl_go_out,
    input wire [15:0] mixed_bits_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire tk = cfg_req_in && ce_in;
    a_ack_same: assert property (cfg_ack_out == tk)
        else $error("ack mismatch");
    a_id_read: assert property (tk && !cfg_wr_in && cfg_index_in == `CFG_OFF_ID |=>
        cfg_rdata_out == {`DEVICE_CODE, `VENDOR_CODE}) else $error("id mismatch");
    a_rdata_hold: assert property (!(tk && !cfg_wr_in) |=> $stable(cfg_rdata_out))
        else $error("rdata moved");
    a_split_free: assert property (reverse_pcix_in && split_cpl_req_in |-> split_cpl_go_out)
        else $error("split blocked");
    a_master_pair: assert property (sec_memio_req_in && fwd_master_req_in |->
        sec_memio_accept_out == pri_master_go_out) else $error("master gates differ");
    a_mixed_primary: assert property (tk && cfg_wr_in && !cfg_from_secondary_in &&
        cfg_index_in == `CFG_OFF_MIXED |=> $stable(mixed_bits_out)) else $error("mixed took write");
    a_mem_write: assert property (tk && cfg_wr_in && cfg_index_in == `CFG_OFF_CMD && cfg_be_in[0] |=>
        !pri_mem_rd_req_in || pri_mem_rd_accept_out == $past(cfg_wdata_in[`CMD_MEM_BIT]))
        else $error("mem gate wrong");
    a_io_reset: assert property (disable iff (1'b0) !arst_n_in |-> !pri_io_accept_out)
        else $error("io open in reset");
    a_master_off: assert property (tk && cfg_wr_in && cfg_index_in == `CFG_OFF_CMD && cfg_be_in[0] &&
        !cfg_wdata_in[`CMD_MASTER_BIT] |=> !sec_memio_accept_out && !pri_master_go_out)
        else $error("master gate open");
endmodule
bind cfg_header cfg_header_monitor u_mon(.*);
`default_nettype wire

// *** tb/cfg_header_tb.sv ***
// Self-checking bench for the configuration header bank.
`default_nettype none
`include "cfg_header_map.vh"
module cfg_header_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, arst_n_in = 0, sr = 0, rq = 0, rv = 0, req, wr, sec, ack, io, mem, smi, mgo, sgo;
    logic [5:0] idx;
    logic [3:0] be;
    logic [31:0] wd, rd;
    logic [15:0] w1c = 0, mx;
    int error_cnt = 0, checks_done = 0;
    initial forever #20 clk_in = ~clk_in;
    cfg_host u_host(.clk_in(clk_in), .req_out(req), .wr_out(wr), .sec_out(sec), .idx_out(idx), .be_out(be),
        .wdata_out(wd));
    cfg_header u_dut(.clk_in(clk_in), .ce_in(1'b1), .arst_n_in(arst_n_in), .sticky_arst_n_in(sr),
        .cfg_req_in(req), .cfg_wr_in(wr), .cfg_from_secondary_in(sec), .cfg_index_in(idx), .cfg_be_in(be),
        .cfg_wdata_in(wd), .cfg_ack_out(ack), .cfg_rdata_out(rd), .w1c_set_in(w1c), .sticky_ro_in(16'h00c3),
        .pri_io_req_in(rq), .pri_mem_rd_req_in(rq), .sec_memio_req_in(rq), .fwd_master_req_in(rq),
        .split_cpl_req_in(rq), .reverse_pcix_in(rv), .pri_io_accept_out(io), .pri_mem_rd_accept_out(mem),
        .sec_memio_accept_out(smi), .pri_master_go_out(mgo), .split_cpl_go_out(sgo), .mixed_bits_out(mx));
    task chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task stop_test();
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task t_cmd();
        u_host.acc(0, 0, `CFG_OFF_CMD, 0);
        chk(rd, 0);
        chk({io, mem, smi, mgo}, 0);
        u_host.acc(1, 0, `CFG_OFF_CMD, 32'h7);
        chk({io, mem, smi, mgo}, 32'hf);
        u_host.acc(1, 1, `CFG_OFF_CMD, 0);
        @(posedge clk_in) rv <= 1;
        #1 chk({io, mem, smi, mgo, sgo}, 32'h1);
    endtask
    task t_ident();
        u_host.acc(1, 1, `CFG_OFF_ID, 32'hffffffff);
        u_host.acc(0, 0, `CFG_OFF_ID, 0);
        chk(rd, {`DEVICE_CODE, `VENDOR_CODE});
    endtask
    task t_mixed();
        u_host.acc(1, 0, `CFG_OFF_MIXED, 32'ha5a5);
        u_host.acc(0, 1, `CFG_OFF_MIXED, 0);
        chk(rd, 0);
        u_host.acc(1, 1, `CFG_OFF_MIXED, 32'ha5a5);
        chk({16'h0, mx}, 32'ha5a5);
    endtask
    task t_clear();
        @(posedge clk_in) w1c <= 16'h0003;
        @(posedge clk_in) w1c <= 0;
        u_host.acc(1, 0, `CFG_OFF_W1C, 32'h1);
        u_host.acc(0, 0, `CFG_OFF_W1C, 0);
        chk(rd, 32'h00c30002);
    endtask
    task t_sticky();
        u_host.acc(1, 0, `CFG_OFF_STICKY, 32'h5a5a);
        @(posedge clk_in) arst_n_in <= 0;
        @(posedge clk_in) arst_n_in <= 1;
        repeat (2) @(posedge clk_in);
        u_host.acc(0, 0, `CFG_OFF_STICKY, 0);
        chk(rd, 32'h00035a5a);
        chk({16'h0, mx}, 0);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        {arst_n_in, sr, rq} <= 3'h7;
        repeat (2) @(posedge clk_in);
        t_cmd();
        t_ident();
        t_mixed();
        t_clear();
        t_sticky();
        stop_test();
    end
endmodule
`default_nettype wire

// *** tb/cfg_host.sv ***
// Host model issuing configuration accesses from either interface.
`default_nettype none
module cfg_host (
    input wire logic clk_in,
    output logic req_out = 0, wr_out = 0, sec_out = 0,
    output logic [5:0] idx_out = 0,
    output logic [3:0] be_out = 0,
    output logic [31:0] wdata_out = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    // The ack is combinational, so the request is dropped at the edge that takes it.
    task acc(input logic w, s, input logic [5:0] i, input logic [31:0] d);
        @(posedge clk_in);
        {req_out, wr_out, sec_out, idx_out, be_out, wdata_out} <= {1'b1, w, s, i, 4'hf, d};
        @(posedge clk_in);
        {req_out, idx_out, wdata_out} <= {1'b0, ~i, ~d};
        #1;
    endtask
endmodule
`default_nettype wire
